/* bwc_chk.sv */
// assertion checker for the bridge window and control block
`timescale 1ns/1ps
module bwc_chk (
	input wire logic        i_clk,
	input wire logic        i_rst_n,
	input wire logic        i_cfg_rd,
	input wire logic [7:0]  i_cfg_addr,
	input wire logic [31:0] o_cfg_rdata,
	input wire logic        o_cfg_rvalid,
	input wire logic        i_req_valid,
	input wire logic        i_req_is_io,
	input wire logic [63:0] i_req_addr,
	input wire logic        o_fwd_valid,
	input wire logic        o_fwd_down,
	input wire logic        o_fwd_up,
	input wire logic        i_sec_poisoned,
	input wire logic        i_sec_err_msg,
	input wire logic        o_poison_report,
	input wire logic        o_err_fwd,
	input wire logic        i_hotplug_event,
	input wire logic        o_inta_assert
);
	// one clock domain, reset disables all
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);
	AST_RVALID: assert property (i_cfg_rd |=> o_cfg_rvalid) else $error("read not answered");
	AST_HOLD: assert property (!i_cfg_rd |=> $stable(o_cfg_rdata)) else $error("read data moved");
	AST_CAP: assert property (i_cfg_rd && i_cfg_addr == 8'h34 |=> o_cfg_rdata == 32'h0000_0040)
		else $error("capability pointer wrong");
	AST_POISON: assert property (o_poison_report |-> $past(i_sec_poisoned)) else $error("stray poison");
	AST_ERR: assert property (o_err_fwd |-> $past(i_sec_err_msg)) else $error("stray error fwd");
	AST_INTA: assert property (o_inta_assert |-> $past(i_hotplug_event)) else $error("stray inta");
	AST_FWD: assert property (i_req_valid |=> o_fwd_valid) else $error("no decode answer");
	AST_ONEWAY: assert property (o_fwd_down || o_fwd_up |-> o_fwd_valid && !(o_fwd_down && o_fwd_up))
		else $error("bad forward flags");
	AST_UP_IO: assert property (o_fwd_up |-> $past(i_req_is_io) && $past(i_req_addr) <= 64'h0000_0000_0000_FFFF
		&& $past(i_req_addr[9:0]) >= 10'h100) else $error("bad upstream forward");
endmodule

bind bwc_regs bwc_chk u_chk (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_cfg_rd(i_cfg_rd), .i_cfg_addr(i_cfg_addr),
	.o_cfg_rdata(o_cfg_rdata), .o_cfg_rvalid(o_cfg_rvalid), .i_req_valid(i_req_valid), .i_req_is_io(i_req_is_io),
	.i_req_addr(i_req_addr), .o_fwd_valid(o_fwd_valid), .o_fwd_down(o_fwd_down), .o_fwd_up(o_fwd_up),
	.i_sec_poisoned(i_sec_poisoned), .i_sec_err_msg(i_sec_err_msg), .o_poison_report(o_poison_report),
	.o_err_fwd(o_err_fwd), .i_hotplug_event(i_hotplug_event), .o_inta_assert(o_inta_assert));

/* bwc_decode.sv */
// forwarding decode: window hit checks for memory and i/o requests
`timescale 1ns/1ps
module bwc_decode (
	// request
	input  wire logic        i_is_io,
	input  wire logic [63:0] i_addr,
	// window bounds
	input  wire logic [63:0] i_mem_base,
	input  wire logic [63:0] i_mem_limit,
	input  wire logic [31:0] i_io_base,
	input  wire logic [31:0] i_io_limit,
	// controls
	input  wire logic        i_isa_en,
	input  wire logic        i_vga_en,
	// result
	output logic             o_fwd_down,
	output logic             o_fwd_up
);
	logic in_win;
	logic isa_alias;
	logic vga_hit;

	// window, isa alias and vga decode
	always_comb begin
		if (i_is_io) begin
			in_win = (i_addr[31:0] >= i_io_base) && (i_addr[31:0] <= i_io_limit) && (i_addr[63:32] == 32'h0);
			isa_alias = i_isa_en && (i_addr[31:0] <= bwc_pkg::IO_64K_LIMIT)
				&& (i_addr[9:0] >= bwc_pkg::ISA_ALIAS_START);
			vga_hit = i_vga_en && (i_addr[31:0] <= bwc_pkg::IO_64K_LIMIT)
				&& (((i_addr[9:0] >= bwc_pkg::VGA_IO_A_LO) && (i_addr[9:0] <= bwc_pkg::VGA_IO_A_HI))
				|| ((i_addr[9:0] >= bwc_pkg::VGA_IO_B_LO) && (i_addr[9:0] <= bwc_pkg::VGA_IO_B_HI)));
		end else begin
			in_win = (i_addr >= i_mem_base) && (i_addr <= i_mem_limit);
			isa_alias = 1'b0;
			vga_hit = i_vga_en && (i_addr[63:32] == 32'h0) && (i_addr[31:0] >= bwc_pkg::VGA_MEM_LO)
				&& (i_addr[31:0] <= bwc_pkg::VGA_MEM_HI);
		end
		o_fwd_up   = in_win && isa_alias && !vga_hit;
		o_fwd_down = (in_win && !isa_alias) || vga_hit;
	end
endmodule

/* bwc_host.sv */
// configuration master model for the primary side
`timescale 1ns/1ps
module bwc_host (
	input  wire logic        i_clk,
	input  wire logic [31:0] i_rdata,
	input  wire logic        i_rvalid,
	output logic             o_wr,
	output logic             o_rd,
	output logic [7:0]       o_addr,
	output logic [3:0]       o_be,
	output logic [31:0]      o_wdata
);
	// idle bus
	initial begin
		{o_wr, o_rd, o_be, o_wdata} = '0;
		o_addr = 8'hFF;
	end
	// one write pulse; released address and data lines show inverted values, byte enables keep theirs
	task automatic wr(input logic [7:0] a, input logic [3:0] b, input logic [31:0] d);
		@(posedge i_clk);
		#1;
		{o_wr, o_addr, o_be, o_wdata} = {1'b1, a, b, d};
		@(posedge i_clk);
		#1;
		{o_wr, o_addr, o_wdata} = {1'b0, ~a, ~d};
	endtask
	// one read pulse; data taken in the answer cycle
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		d = 'x;
		@(posedge i_clk);
		#1;
		{o_rd, o_addr} = {1'b1, a};
		@(posedge i_clk);
		#1;
		{o_rd, o_addr} = {1'b0, ~a};
		if (i_rvalid === 1'b1) begin
			d = i_rdata;
		end
	endtask
endmodule

/* bwc_pkg.sv */
// package: register offsets, fields, reset values and address constants
package bwc_pkg;
	// config dword offsets
	localparam logic [7:0]  OFS_PREF_LIMIT_HI = 8'h2C;
	localparam logic [7:0]  OFS_IO_HIGH       = 8'h30;
	localparam logic [7:0]  OFS_CAP_PTR       = 8'h34;
	localparam logic [7:0]  OFS_INTR_BRCTL    = 8'h3C;
	// reset values
	localparam logic [31:0] RST_PREF_LIMIT_HI = 32'h0000_0000;
	localparam logic [15:0] RST_IO_HALF       = 16'h0000;
	localparam logic [7:0]  RST_CAP_PTR       = 8'h40;
	localparam logic [7:0]  RST_INTR_LINE     = 8'h00;
	localparam logic [7:0]  RST_INTR_PIN      = 8'h00;
	localparam logic [3:0]  RST_BRCTL         = 4'h0;
	// bridge control bit positions within dword 3Ch
	localparam int          BIT_PERR_RESP     = 16;
	localparam int          BIT_SEC_ERR_FWD   = 17;
	localparam int          BIT_ISA_EN        = 18;
	localparam int          BIT_VGA_EN        = 19;
	// address constants
	localparam logic [19:0] LIMIT_LOW_ONES    = 20'hFFFFF;
	localparam logic [31:0] VGA_MEM_LO        = 32'h000A_0000;
	localparam logic [31:0] VGA_MEM_HI        = 32'h000B_FFFF;
	localparam logic [9:0]  VGA_IO_A_LO       = 10'h3B0;
	localparam logic [9:0]  VGA_IO_A_HI       = 10'h3BB;
	localparam logic [9:0]  VGA_IO_B_LO       = 10'h3C0;
	localparam logic [9:0]  VGA_IO_B_HI       = 10'h3DF;
	localparam logic [9:0]  ISA_ALIAS_START   = 10'h100;
	localparam logic [31:0] IO_64K_LIMIT      = 32'h0000_FFFF;
endpackage

/* bwc_regs.sv */
// bridge window upper halves, interrupt and bridge control registers
//
// Summary of operation
// - prefetch limit upper 32 bits, RW, reset zero
// - i/o base upper 16 bits, RW, reset zero
// - i/o limit upper 16 bits, RW, reset zero
// - capability pointer reads 40h, read only
// - interrupt pin read only, resets to 00h; hot-plug drives INTA only while the pin is nonzero
// - interrupt pin overridable by management or eeprom
// - bit 16: report poisoned tlps, else ignore
// - bit 17 gates error message forwarding upstream
// - bit 18 sends isa alias i/o upstream
// - bit 19 clear blocks vga range forwarding except where the address falls inside the i/o or memory window
// - bit 19 set forwards vga ranges
// - prefetch limit low twenty bits all ones
`timescale 1ns/1ps
module bwc_regs (
	// clock and reset
	input  wire logic        i_clk,
	input  wire logic        i_rst_n,
	// config access, dword offset with byte enables
	input  wire logic        i_cfg_wr,
	input  wire logic        i_cfg_rd,
	input  wire logic [7:0]  i_cfg_addr,
	input  wire logic [3:0]  i_cfg_be,
	input  wire logic [31:0] i_cfg_wdata,
	output logic [31:0]      o_cfg_rdata,
	output logic             o_cfg_rvalid,
	// interrupt pin override from management or eeprom load
	input  wire logic        i_pin_ovr_we,
	input  wire logic [7:0]  i_pin_ovr_val,
	// prefetch base upper half and lower window halves held elsewhere in the header
	input  wire logic [31:0] i_pref_base_hi,
	input  wire logic [11:0] i_pref_base_lo,
	input  wire logic [11:0] i_pref_limit_lo,
	input  wire logic [15:0] i_io_base_lo,
	input  wire logic [15:0] i_io_limit_lo,
	// request to classify
	input  wire logic        i_req_valid,
	input  wire logic        i_req_is_io,
	input  wire logic [63:0] i_req_addr,
	output logic             o_fwd_valid,
	output logic             o_fwd_down,
	output logic             o_fwd_up,
	// secondary side events
	input  wire logic        i_sec_poisoned,
	input  wire logic        i_sec_err_msg,
	output logic             o_poison_report,
	output logic             o_err_fwd,
	// hot-plug interrupt virtual wire
	input  wire logic        i_hotplug_event,
	output logic             o_inta_assert
);
	logic [31:0] pref_limit_hi_r, pref_limit_hi_nxt;
	logic [15:0] io_base_hi_r, io_base_hi_nxt;
	logic [15:0] io_limit_hi_r, io_limit_hi_nxt;
	logic [7:0]  intr_line_r, intr_line_nxt;
	logic [7:0]  intr_pin_r, intr_pin_nxt;
	logic [3:0]  brctl_r, brctl_nxt;
	logic [31:0] rdata_r, rdata_nxt;
	logic        rvalid_r, rvalid_nxt;
	logic        fwd_valid_r, fwd_valid_nxt;
	logic        fwd_down_r, fwd_down_nxt;
	logic        fwd_up_r, fwd_up_nxt;
	logic        poison_r, poison_nxt;
	logic        err_fwd_r, err_fwd_nxt;
	logic        inta_r, inta_nxt;
	logic [63:0] mem_base;
	logic [63:0] mem_limit;
	logic [31:0] io_base;
	logic [31:0] io_limit;
	logic        dec_down;
	logic        dec_up;

	// merge a byte-enabled write into a dword
	function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd,
		input logic [3:0] be);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				res[i*8 +: 8] = wd[i*8 +: 8];
			end
		end
		return res;
	endfunction

	// composed window bounds
	assign mem_base  = {i_pref_base_hi, i_pref_base_lo, 20'h00000};
	assign mem_limit = {pref_limit_hi_r, i_pref_limit_lo, bwc_pkg::LIMIT_LOW_ONES};
	assign io_base   = {io_base_hi_r, i_io_base_lo};
	assign io_limit  = {io_limit_hi_r, i_io_limit_lo};

	// window decode
	bwc_decode u_decode (
		.i_is_io     (i_req_is_io),
		.i_addr      (i_req_addr),
		.i_mem_base  (mem_base),
		.i_mem_limit (mem_limit),
		.i_io_base   (io_base),
		.i_io_limit  (io_limit),
		.i_isa_en    (brctl_r[bwc_pkg::BIT_ISA_EN - 16]),
		.i_vga_en    (brctl_r[bwc_pkg::BIT_VGA_EN - 16]),
		.o_fwd_down  (dec_down),
		.o_fwd_up    (dec_up)
	);

	// register writes from the config bus and the pin override
	always_comb begin
		logic [31:0] m;
		m = 32'h0;
		pref_limit_hi_nxt = pref_limit_hi_r;
		io_base_hi_nxt    = io_base_hi_r;
		io_limit_hi_nxt   = io_limit_hi_r;
		intr_line_nxt     = intr_line_r;
		intr_pin_nxt      = intr_pin_r;
		brctl_nxt         = brctl_r;
		if (i_cfg_wr) begin
			unique case (i_cfg_addr)
				bwc_pkg::OFS_PREF_LIMIT_HI: begin
					pref_limit_hi_nxt = be_merge(pref_limit_hi_r, i_cfg_wdata, i_cfg_be);
				end
				bwc_pkg::OFS_IO_HIGH: begin
					m = be_merge({io_limit_hi_r, io_base_hi_r}, i_cfg_wdata, i_cfg_be);
					io_base_hi_nxt  = m[15:0];
					io_limit_hi_nxt = m[31:16];
				end
				bwc_pkg::OFS_INTR_BRCTL: begin
					m = be_merge({12'h000, brctl_r, 8'h00, intr_line_r}, i_cfg_wdata, i_cfg_be);
					intr_line_nxt = m[7:0];
					brctl_nxt     = m[bwc_pkg::BIT_VGA_EN:bwc_pkg::BIT_PERR_RESP];
				end
				default: begin
				end
			endcase
		end
		// pin byte is read only on the bus, so only the override port moves it
		if (i_pin_ovr_we) begin
			intr_pin_nxt = i_pin_ovr_val;
		end
	end

	// read mux: a read beside a write in one cycle returns the old value
	always_comb begin
		rdata_nxt  = rdata_r;
		rvalid_nxt = i_cfg_rd;
		if (i_cfg_rd) begin
			unique case (i_cfg_addr)
				bwc_pkg::OFS_PREF_LIMIT_HI: rdata_nxt = pref_limit_hi_r;
				bwc_pkg::OFS_IO_HIGH:       rdata_nxt = {io_limit_hi_r, io_base_hi_r};
				bwc_pkg::OFS_CAP_PTR:       rdata_nxt = {24'h000000, bwc_pkg::RST_CAP_PTR};
				bwc_pkg::OFS_INTR_BRCTL:    rdata_nxt = {12'h000, brctl_r, intr_pin_r, intr_line_r};
				default:                    rdata_nxt = 32'h0000_0000;
			endcase
		end
	end

	// forwarding, error and interrupt outputs
	always_comb begin
		fwd_valid_nxt = i_req_valid;
		fwd_down_nxt  = i_req_valid && dec_down;
		fwd_up_nxt    = i_req_valid && dec_up;
		poison_nxt    = i_sec_poisoned && brctl_r[bwc_pkg::BIT_PERR_RESP - 16];
		err_fwd_nxt   = i_sec_err_msg && brctl_r[bwc_pkg::BIT_SEC_ERR_FWD - 16];
		inta_nxt      = i_hotplug_event && (intr_pin_r != 8'h00);
	end

	// config register state
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			pref_limit_hi_r <= bwc_pkg::RST_PREF_LIMIT_HI;
			io_base_hi_r    <= bwc_pkg::RST_IO_HALF;
			io_limit_hi_r   <= bwc_pkg::RST_IO_HALF;
			intr_line_r     <= bwc_pkg::RST_INTR_LINE;
			intr_pin_r      <= bwc_pkg::RST_INTR_PIN;
			brctl_r         <= bwc_pkg::RST_BRCTL;
		end else begin
			pref_limit_hi_r <= pref_limit_hi_nxt;
			io_base_hi_r    <= io_base_hi_nxt;
			io_limit_hi_r   <= io_limit_hi_nxt;
			intr_line_r     <= intr_line_nxt;
			intr_pin_r      <= intr_pin_nxt;
			brctl_r         <= brctl_nxt;
		end
	end

	// read path state
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rdata_r  <= 32'h0000_0000;
			rvalid_r <= 1'b0;
		end else begin
			rdata_r  <= rdata_nxt;
			rvalid_r <= rvalid_nxt;
		end
	end

	// forwarding, event and interrupt state
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			fwd_valid_r <= 1'b0;
			fwd_down_r  <= 1'b0;
			fwd_up_r    <= 1'b0;
			poison_r    <= 1'b0;
			err_fwd_r   <= 1'b0;
			inta_r      <= 1'b0;
		end else begin
			fwd_valid_r <= fwd_valid_nxt;
			fwd_down_r  <= fwd_down_nxt;
			fwd_up_r    <= fwd_up_nxt;
			poison_r    <= poison_nxt;
			err_fwd_r   <= err_fwd_nxt;
			inta_r      <= inta_nxt;
		end
	end

	// outputs straight from flops
	assign o_cfg_rdata     = rdata_r;
	assign o_cfg_rvalid    = rvalid_r;
	assign o_fwd_valid     = fwd_valid_r;
	assign o_fwd_down      = fwd_down_r;
	assign o_fwd_up        = fwd_up_r;
	assign o_poison_report = poison_r;
	assign o_err_fwd       = err_fwd_r;
	assign o_inta_assert   = inta_r;
endmodule

/* tb_bridge_window_and_control_regs.sv */
// self-checking testbench for the bridge window and control block
`timescale 1ns/1ps
module tb_bridge_window_and_control_regs;
	logic        i_clk = 1'b0;
	logic        i_rst_n = 1'b0;
	logic        wr, rd, rvalid, ovr_we, req_v, req_io, fv, fd, fu, poi, err, prep, efwd, hp, inta;
	logic [7:0]  addr, ovr_val;
	logic [3:0]  be;
	logic [31:0] wdata, rdata, pbh, got;
	logic [11:0] pbl, pll;
	logic [15:0] iob, iol;
	logic [63:0] req_a;
	int          err_count = 0;
	int          checks_done = 0;

	always #2.5 i_clk = ~i_clk;

	bwc_host i_host (.i_clk(i_clk), .i_rdata(rdata), .i_rvalid(rvalid), .o_wr(wr), .o_rd(rd), .o_addr(addr),
		.o_be(be), .o_wdata(wdata));
	bwc_regs i_dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_cfg_wr(wr), .i_cfg_rd(rd), .i_cfg_addr(addr),
		.i_cfg_be(be), .i_cfg_wdata(wdata), .o_cfg_rdata(rdata), .o_cfg_rvalid(rvalid), .i_pin_ovr_we(ovr_we),
		.i_pin_ovr_val(ovr_val), .i_pref_base_hi(pbh), .i_pref_base_lo(pbl), .i_pref_limit_lo(pll),
		.i_io_base_lo(iob), .i_io_limit_lo(iol), .i_req_valid(req_v), .i_req_is_io(req_io), .i_req_addr(req_a),
		.o_fwd_valid(fv), .o_fwd_down(fd), .o_fwd_up(fu), .i_sec_poisoned(poi), .i_sec_err_msg(err),
		.o_poison_report(prep), .o_err_fwd(efwd), .i_hotplug_event(hp), .o_inta_assert(inta));

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checks_done++;
		if (g !== e) begin
			err_count++;
			$display("Error at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	// read one dword and compare
	task automatic rchk(input logic [7:0] a, input logic [31:0] e);
		i_host.rd(a, got);
		chk(got, e);
	endtask
	// classify one request: expected {down, up}
	task automatic req(input logic io, input logic [63:0] a, input logic [1:0] e);
		@(posedge i_clk);
		#1;
		{req_v, req_io, req_a} = {1'b1, io, a};
		@(posedge i_clk);
		#1;
		{req_v, req_a} = {1'b0, ~a};
		chk({29'h0, fv, fd, fu}, {29'h0, 1'b1, e});
	endtask
	// one-cycle secondary side events
	task automatic ev(input logic p, input logic e, input logic h);
		@(posedge i_clk);
		#1;
		{poi, err, hp} = {p, e, h};
		@(posedge i_clk);
		#1;
		{poi, err, hp} = 3'h0;
	endtask
	task automatic t_regs();
		rchk(8'h2C, 32'h0000_0000);
		rchk(8'h30, 32'h0000_0000);
		rchk(8'h3C, 32'h0000_0000);
		i_host.wr(8'h2C, 4'hF, 32'hA5C3_0001);
		i_host.wr(8'h30, 4'h3, 32'h1234_5678);
		i_host.wr(8'h34, 4'hF, 32'hFFFF_FFFF);
		i_host.wr(8'h3C, 4'hF, 32'hFFF0_FF5A);
		i_host.wr(8'h00, 4'hF, 32'hFFFF_FFFF);
		rchk(8'h2C, 32'hA5C3_0001);
		rchk(8'h30, 32'h0000_5678);
		i_host.wr(8'h30, 4'hC, 32'h9ABC_0000);
		rchk(8'h30, 32'h9ABC_5678);
		rchk(8'h34, 32'h0000_0040);
		rchk(8'h3C, 32'h0000_005A);
		rchk(8'h00, 32'h0000_0000);
		$display("test registers done");
	endtask
	task automatic t_events();
		for (int k = 0; k < 4; k++) begin
			i_host.wr(8'h3C, 4'h4, {12'h000, k[3:0], 16'h0000});
			ev(1'b1, 1'b1, 1'b0);
			chk({30'h0, prep, efwd}, {30'h0, k[0], k[1]});
		end
		ev(1'b0, 1'b0, 1'b1);
		chk({31'h0, inta}, 32'h0);
		@(posedge i_clk);
		#1;
		{ovr_we, ovr_val} = {1'b1, 8'h01};
		@(posedge i_clk);
		#1;
		ovr_we = 1'b0;
		rchk(8'h3C, 32'h0003_015A);
		ev(1'b0, 1'b0, 1'b1);
		chk({31'h0, inta}, 32'h1);
		$display("test events done");
	endtask
	// mid-run reset returns every register to its default
	task automatic t_reset();
		@(posedge i_clk);
		#1;
		i_rst_n = 1'b0;
		repeat (3) @(posedge i_clk);
		#1;
		i_rst_n = 1'b1;
		rchk(8'h2C, 32'h0000_0000);
		rchk(8'h30, 32'h0000_0000);
		rchk(8'h3C, 32'h0000_0000);
		$display("test reset done");
	endtask
	task automatic t_decode();
		{pbl, pll, iob, iol} = {12'h001, 12'h002, 16'h1000, 16'h1FFF};
		i_host.wr(8'h2C, 4'hF, 32'h0000_0001);
		i_host.wr(8'h30, 4'hF, 32'h0000_0000);
		i_host.wr(8'h3C, 4'h4, 32'h0000_0000);
		req(1'b0, 64'h0000_0000_0010_0000, 2'b10);
		req(1'b0, 64'h0000_0000_000F_FFFF, 2'b00);
		req(1'b0, 64'h0000_0001_002F_FFFF, 2'b10);
		req(1'b0, 64'h0000_0001_0030_0000, 2'b00);
		req(1'b1, 64'h0000_0000_0000_0FFF, 2'b00);
		req(1'b1, 64'h0000_0000_0000_1FFF, 2'b10);
		req(1'b1, 64'h0000_0000_0000_1100, 2'b10);
		req(1'b0, 64'h0000_0000_000A_0000, 2'b00);
		i_host.wr(8'h3C, 4'h4, 32'h0004_0000);
		req(1'b1, 64'h0000_0000_0000_1100, 2'b01);
		req(1'b1, 64'h0000_0000_0000_1000, 2'b10);
		i_host.wr(8'h3C, 4'h4, 32'h0008_0000);
		req(1'b0, 64'h0000_0000_000A_0000, 2'b10);
		req(1'b0, 64'h0000_0000_000B_FFFF, 2'b10);
		req(1'b0, 64'h0000_0000_000C_0000, 2'b00);
		req(1'b1, 64'h0000_0000_0000_03B0, 2'b10);
		req(1'b1, 64'h0000_0000_0000_03DF, 2'b10);
		req(1'b1, 64'h0000_0000_0000_03BC, 2'b00);
		i_host.wr(8'h30, 4'hF, 32'h0001_0001);
		req(1'b1, 64'h0000_0000_0001_1100, 2'b10);
		req(1'b1, 64'h0000_0000_0000_1100, 2'b00);
		$display("test decode done");
	endtask

	// main sequence
	initial begin
		{ovr_we, req_v, req_io, poi, err, hp, ovr_val, pbh, pbl, pll, iob, iol, req_a} = '0;
		repeat (20) @(posedge i_clk);
		#1;
		i_rst_n = 1'b1;
		t_regs();
		t_events();
		t_reset();
		t_decode();
		end_of_test();
	end
	// hang guard
	initial begin
		repeat (5000) @(posedge i_clk);
		err_count++;
		end_of_test();
	end
endmodule
